// file: togc_cnt_if.sv
// Carrier between the top block and one channel counter
`timescale 1ns/1ps
interface togc_cnt_if #(parameter int CNT_W = 16);
    logic tick;
    logic downEn;
    logic clear;
    logic standby;
    logic [1:0] wrByte;
    logic [CNT_W-1:0] wrData;
    logic [CNT_W-1:0] count;
    logic wrapPulse;

    modport ctrl (output tick, output downEn, output clear, output standby,
                  output wrByte, output wrData, input count, input wrapPulse);
    modport cnt (input tick, input downEn, input clear, input standby,
                 input wrByte, input wrData, output count, output wrapPulse);
endinterface

// file: togc_counter.sv
// One 16-bit channel counter with clear, byte write and wrap detection
`timescale 1ns/1ps
module togc_counter
    import togc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    togc_cnt_if.cnt bus
);

    generate
        if (CNT_W != TOGC_CNT_W) begin : g_bad_width
            $error("togc_counter supports only 16-bit counters");
        end
    endgenerate

    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic wrap_ff;
    logic nxt_wrap;

    always_comb begin
        nxt_count = count_ff;
        nxt_wrap = 1'b0;
        if (bus.standby) begin
            nxt_count = TOGC_CNT_RST;
        end else if (bus.wrByte != 2'b00) begin
            if (bus.wrByte[1]) begin
                nxt_count[CNT_W-1:8] = bus.wrData[CNT_W-1:8];
            end
            if (bus.wrByte[0]) begin
                nxt_count[7:0] = bus.wrData[7:0];
            end
        end else if (bus.clear) begin
            nxt_count = TOGC_CNT_RST;
        end else if (bus.tick) begin
            if (bus.downEn) begin
                nxt_count = count_ff - CNT_W'(1);
                nxt_wrap = (count_ff == TOGC_CNT_RST);
            end else begin
                nxt_count = count_ff + CNT_W'(1);
                nxt_wrap = (count_ff == TOGC_CNT_MAX);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_ff <= TOGC_CNT_RST;
            wrap_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            wrap_ff <= nxt_wrap;
        end
    end

    assign bus.count = count_ff;
    assign bus.wrapPulse = wrap_ff;

endmodule

// file: togc_monitor.sv
// Port checker for the timer output gate and counters
`timescale 1ns/1ps
module togc_monitor
    import togc_pkg::*;
#(
    parameter int NUM_CH = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic standby,
    input wire logic [2:0] cpuAddr,
    input wire logic cpuRd,
    input wire logic [15:0] cpuRdData,
    input wire logic [1:0] combModeField,
    input wire logic [7:0] tickSources,
    input wire logic [5:0] timerPinLevel,
    input wire logic [5:0] timerPinDrive,
    input wire logic [5:0] pinOut,
    input wire logic [5:0] pinOe,
    input wire logic [NUM_CH-1:0] overflowSet
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    oe_after_reset_a:
        assert property ($past(rst, 2) && !$past(rst) |-> pinOe == $past(timerPinDrive))
        else $error("enable not set after reset");
    oe_needs_drive_a:
        assert property ((pinOe & ~$past(timerPinDrive)) == 6'h00)
        else $error("pin enabled without drive");
    plain_level_a:
        assert property (!$past(rst) && !$past(combModeField[1])
            |-> pinOut == $past(timerPinLevel))
        else $error("pin inverted in normal mode");
    enable_fixed_a:
        assert property (cpuRd && cpuAddr == 3'h0 |=> cpuRdData[15:6] == 10'h003)
        else $error("enable fixed bits wrong");
    control_fixed_a:
        assert property (cpuRd && cpuAddr == 3'h1
            |=> cpuRdData[15:5] == 11'h007 && cpuRdData[3:2] == 2'h3)
        else $error("control fixed bits wrong");
    unmapped_read_a:
        assert property (cpuRd && cpuAddr == 3'h7 |=> cpuRdData == 16'h0000)
        else $error("unmapped read not zero");
    standby_init_a:
        assert property ($past(standby) && cpuRd
            |=> cpuRdData == ($past(cpuAddr) < 3'h2 ? 16'h00FF : 16'h0000))
        else $error("standby init wrong");
    wrap_tick_a:
        assert property (overflowSet != 0 |-> $past(tickSources) != 8'h00)
        else $error("wrap without tick");
    wrap_pulse_a:
        assert property (overflowSet[1:0] != 2'b00 |=> overflowSet[1:0] == 2'b00)
        else $error("wrap pulse too long");
endmodule
bind togc_timer_unit togc_monitor #(.NUM_CH(NUM_CH)) togcMon (
    .clk(clk), .rst(rst), .standby(standby), .cpuAddr(cpuAddr), .cpuRd(cpuRd),
    .cpuRdData(cpuRdData), .combModeField(combModeField), .tickSources(tickSources),
    .timerPinLevel(timerPinLevel), .timerPinDrive(timerPinDrive), .pinOut(pinOut),
    .pinOe(pinOe), .overflowSet(overflowSet));

// file: togc_pin_load.sv
// Pin loads with pull-ups on the six timer pins
`timescale 1ns/1ps
module togc_pin_load (
    input wire logic [5:0] pinOut,
    input wire logic [5:0] pinOe,
    output logic [5:0] padLevel
);
    // Released pin is general I/O and pulls high
    assign padLevel = (pinOut & pinOe) | ~pinOe;
endmodule

// file: togc_pkg.sv
// Shared constants and types for the timer output gate and channel counters
package togc_pkg;

    localparam int TOGC_NUM_CH = 5;
    localparam int TOGC_CNT_W = 16;
    localparam int TOGC_ADDR_W = 3;
    localparam int TOGC_NUM_PINS = 6;

    // Register indexes on the internal bus
    localparam logic [2:0] TOGC_IDX_OUT_MASTER_EN = 3'h0;
    localparam logic [2:0] TOGC_IDX_OUT_CTRL = 3'h1;
    localparam logic [2:0] TOGC_IDX_CNT_BASE = 3'h2;

    // Reset values and counter maximum
    localparam logic [7:0] TOGC_OUT_MASTER_EN_RST = 8'hFF;
    localparam logic [7:0] TOGC_OUT_CTRL_RST = 8'hFF;
    localparam logic [15:0] TOGC_CNT_RST = 16'h0000;
    localparam logic [15:0] TOGC_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOGC_RD_UNMAPPED = 16'h0000;

    // Read-only ones in the two 8-bit registers
    localparam logic [1:0] TOGC_OME_FIXED = 2'h3;
    localparam logic [2:0] TOGC_OCTL_FIXED_HI = 3'h7;
    localparam logic [1:0] TOGC_OCTL_FIXED_MID = 2'h3;

    // Output control field positions
    localparam int TOGC_OCTL_TRIG_DIS_BIT = 4;
    localparam int TOGC_OCTL_OLS_HI_BIT = 1;
    localparam int TOGC_OCTL_OLS_LO_BIT = 0;

    // Pin index = master enable bit position
    localparam int TOGC_PIN_CH3_A = 0;
    localparam int TOGC_PIN_CH4_A = 1;
    localparam int TOGC_PIN_CH4_B = 2;
    localparam int TOGC_PIN_CH3_B = 3;
    localparam int TOGC_PIN_AUX_A = 4;
    localparam int TOGC_PIN_AUX_B = 5;

    // Pins inverted by each level select bit
    localparam logic [5:0] TOGC_OLS_HI_MASK = 6'h07;
    localparam logic [5:0] TOGC_OLS_LO_MASK = 6'h38;

    typedef enum logic [1:0] {
        TOGC_CMB_NORMAL0 = 2'b00,
        TOGC_CMB_NORMAL1 = 2'b01,
        TOGC_CMB_COMP_PWM = 2'b10,
        TOGC_CMB_RSYNC_PWM = 2'b11
    } togc_comb_mode_t;

endpackage

// file: togc_timer_unit.sv
// Output master enable gate, output control and five channel counters
`timescale 1ns/1ps
module togc_timer_unit
    import togc_pkg::*;
#(
    parameter int NUM_CH = TOGC_NUM_CH,
    parameter int CNT_W = TOGC_CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic standby,
    input wire logic [TOGC_ADDR_W-1:0] cpuAddr,
    input wire logic cpuWr,
    input wire logic cpuRd,
    input wire logic [1:0] cpuByteEn,
    input wire logic [CNT_W-1:0] cpuWrData,
    output logic [CNT_W-1:0] cpuRdData,
    input wire logic [1:0] combModeField,
    input wire logic ch2PhaseMode,
    input wire logic [7:0] tickSources,
    input wire logic [3*NUM_CH-1:0] prescalerSelect,
    input wire logic [NUM_CH-1:0] countDownReq,
    input wire logic [NUM_CH-1:0] clearReq,
    input wire logic ch1CaptureA,
    input wire logic [TOGC_NUM_PINS-1:0] timerPinLevel,
    input wire logic [TOGC_NUM_PINS-1:0] timerPinDrive,
    output logic [TOGC_NUM_PINS-1:0] pinOut,
    output logic [TOGC_NUM_PINS-1:0] pinOe,
    output logic [NUM_CH-1:0] overflowSet
);

    generate
        if (NUM_CH != TOGC_NUM_CH || CNT_W != TOGC_CNT_W) begin : g_bad_cfg
            $error("togc_timer_unit supports only five 16-bit channels");
        end
    endgenerate

    togc_comb_mode_t combMode;
    logic pwmComboMode;
    logic [NUM_CH-1:0] downAllowed;
    logic [NUM_CH-1:0] cntWrSel;
    logic [NUM_CH-1:0] wrapAll;
    logic [CNT_W-1:0] cntValue [NUM_CH];

    logic [5:0] outEnable_ff;
    logic [5:0] nxt_outEnable;
    logic trigDis_ff;
    logic nxt_trigDis;
    logic [1:0] ols_ff;
    logic [1:0] nxt_ols;
    logic [CNT_W-1:0] rdData_ff;
    logic [CNT_W-1:0] nxt_rdData;
    logic [TOGC_NUM_PINS-1:0] pinOut_ff;
    logic [TOGC_NUM_PINS-1:0] nxt_pinOut;
    logic [TOGC_NUM_PINS-1:0] pinOe_ff;
    logic [TOGC_NUM_PINS-1:0] nxt_pinOe;
    logic [TOGC_NUM_PINS-1:0] invMask;
    logic [TOGC_NUM_PINS-1:0] gatedDrive;
    logic extTrigger;
    logic wrOme;
    logic wrOctl;

    assign combMode = togc_comb_mode_t'(combModeField);
    // Both PWM combination modes
    assign pwmComboMode = (combMode == TOGC_CMB_COMP_PWM) ||
                          (combMode == TOGC_CMB_RSYNC_PWM);

    // Direction permission per channel
    always_comb begin
        downAllowed = '0;
        downAllowed[2] = ch2PhaseMode;
        downAllowed[3] = (combMode == TOGC_CMB_COMP_PWM);
        downAllowed[4] = (combMode == TOGC_CMB_COMP_PWM);
    end

    // Address decode
    always_comb begin
        wrOme = 1'b0;
        wrOctl = 1'b0;
        cntWrSel = '0;
        if (cpuWr && cpuAddr == TOGC_IDX_OUT_MASTER_EN) begin
            wrOme = cpuByteEn[0];
        end else if (cpuWr && cpuAddr == TOGC_IDX_OUT_CTRL) begin
            wrOctl = cpuByteEn[0];
        end else if (cpuWr && cpuAddr >= TOGC_IDX_CNT_BASE) begin
            for (int k = 0; k < NUM_CH; k++) begin
                cntWrSel[k] = (cpuAddr == TOGC_IDX_CNT_BASE + 3'(k));
            end
        end
    end

    // Channel counters
    togc_cnt_if #(.CNT_W(CNT_W)) cntIf [NUM_CH] ();

    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
            assign cntIf[i].tick = tickSources[prescalerSelect[3*i +: 3]];
            assign cntIf[i].downEn = countDownReq[i] & downAllowed[i];
            assign cntIf[i].clear = clearReq[i];
            assign cntIf[i].standby = standby;
            assign cntIf[i].wrByte = cntWrSel[i] ? cpuByteEn : 2'b00;
            assign cntIf[i].wrData = cpuWrData;
            assign cntValue[i] = cntIf[i].count;
            assign wrapAll[i] = cntIf[i].wrapPulse;

            togc_counter #(.CNT_W(CNT_W)) u_cnt (
                .clk(clk),
                .rst(rst),
                .bus(cntIf[i])
            );
        end
    endgenerate

    assign overflowSet = wrapAll;

    // Trigger only in PWM combination modes with trigger enabled
    assign extTrigger = ch1CaptureA && !trigDis_ff && pwmComboMode;

    // Control register next values
    always_comb begin
        nxt_outEnable = outEnable_ff;
        nxt_trigDis = trigDis_ff;
        nxt_ols = ols_ff;
        if (standby) begin
            nxt_outEnable = TOGC_OUT_MASTER_EN_RST[5:0];
            nxt_trigDis = TOGC_OUT_CTRL_RST[TOGC_OCTL_TRIG_DIS_BIT];
            nxt_ols = TOGC_OUT_CTRL_RST[1:0];
        end else begin
            if (wrOme) begin
                nxt_outEnable = cpuWrData[5:0];
            end
            if (extTrigger) begin
                nxt_outEnable = 6'h00;
            end
            if (wrOctl) begin
                nxt_trigDis = cpuWrData[TOGC_OCTL_TRIG_DIS_BIT];
                nxt_ols[1] = cpuWrData[TOGC_OCTL_OLS_HI_BIT];
                nxt_ols[0] = cpuWrData[TOGC_OCTL_OLS_LO_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            outEnable_ff <= TOGC_OUT_MASTER_EN_RST[5:0];
            trigDis_ff <= TOGC_OUT_CTRL_RST[TOGC_OCTL_TRIG_DIS_BIT];
            ols_ff <= TOGC_OUT_CTRL_RST[1:0];
        end else begin
            outEnable_ff <= nxt_outEnable;
            trigDis_ff <= nxt_trigDis;
            ols_ff <= nxt_ols;
        end
    end

    // Read path
    always_comb begin
        nxt_rdData = rdData_ff;
        if (cpuRd) begin
            if (cpuAddr == TOGC_IDX_OUT_MASTER_EN) begin
                nxt_rdData = {8'h00, TOGC_OME_FIXED, outEnable_ff};
            end else if (cpuAddr == TOGC_IDX_OUT_CTRL) begin
                nxt_rdData = {8'h00, TOGC_OCTL_FIXED_HI, trigDis_ff,
                              TOGC_OCTL_FIXED_MID, ols_ff};
            end else if (cpuAddr >= TOGC_IDX_CNT_BASE &&
                         cpuAddr < TOGC_IDX_CNT_BASE + 3'(NUM_CH)) begin
                nxt_rdData = cntValue[cpuAddr - TOGC_IDX_CNT_BASE];
            end else begin
                nxt_rdData = TOGC_RD_UNMAPPED;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_ff <= TOGC_RD_UNMAPPED;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign cpuRdData = rdData_ff;

    // Master enable gate, pin index equals enable bit
    generate
        for (genvar p = 0; p < TOGC_NUM_PINS; p++) begin : g_pin
            assign gatedDrive[p] = timerPinDrive[p] & outEnable_ff[p];
        end
    endgenerate

    // Pin gating and level inversion
    always_comb begin
        invMask = '0;
        if (pwmComboMode) begin
            if (!ols_ff[1]) begin
                invMask = invMask | TOGC_OLS_HI_MASK;
            end
            if (!ols_ff[0]) begin
                invMask = invMask | TOGC_OLS_LO_MASK;
            end
        end
        nxt_pinOut = timerPinLevel ^ invMask;
        nxt_pinOe = gatedDrive;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pinOut_ff <= '0;
            pinOe_ff <= '0;
        end else begin
            pinOut_ff <= nxt_pinOut;
            pinOe_ff <= nxt_pinOe;
        end
    end

    assign pinOut = pinOut_ff;
    assign pinOe = pinOe_ff;

endmodule

// file: togc_timer_unit_tb.sv
// Self-checking bench for the timer output gate and counters
`timescale 1ns/1ps
module togc_timer_unit_tb
    import togc_pkg::*;
;
    logic clk = 0, rst = 1, standby = 0, cpuWr = 0, cpuRd = 0;
    logic ch2PhaseMode = 0, ch1CaptureA = 0, dn;
    logic [2:0] cpuAddr = 0;
    logic [1:0] cpuByteEn = 0, combModeField = 0;
    logic [15:0] cpuWrData = 0, cpuRdData;
    logic [7:0] tickSources = 0;
    // Channel c counts on source 7-c
    logic [14:0] prescalerSelect = 15'h3977;
    logic [4:0] countDownReq = 0, clearReq = 0, overflowSet;
    logic [5:0] timerPinLevel = 0, timerPinDrive = 6'h3F, pinOut, pinOe, padLevel;
    int failCount = 0, comparisons = 0, cycles = 0;
    togc_timer_unit DUT (
        .clk(clk), .rst(rst), .standby(standby), .cpuAddr(cpuAddr), .cpuWr(cpuWr),
        .cpuRd(cpuRd), .cpuByteEn(cpuByteEn), .cpuWrData(cpuWrData), .cpuRdData(cpuRdData),
        .combModeField(combModeField), .ch2PhaseMode(ch2PhaseMode), .tickSources(tickSources),
        .prescalerSelect(prescalerSelect), .countDownReq(countDownReq), .clearReq(clearReq),
        .ch1CaptureA(ch1CaptureA), .timerPinLevel(timerPinLevel),
        .timerPinDrive(timerPinDrive), .pinOut(pinOut), .pinOe(pinOe),
        .overflowSet(overflowSet));
    togc_pin_load load (.pinOut(pinOut), .pinOe(pinOe), .padLevel(padLevel));
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failCount++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [1:0] be, logic [15:0] d);
        cpuWr <= 1'b1;
        cpuAddr <= a;
        cpuByteEn <= be;
        cpuWrData <= d;
        @(posedge clk);
        cpuWr <= 1'b0;
        ch1CaptureA <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [2:0] a, logic [15:0] exp);
        cpuRd <= 1'b1;
        cpuAddr <= a;
        @(posedge clk);
        cpuRd <= 1'b0;
        #1 chk("cpuRdData", exp, cpuRdData);
        @(posedge clk);
    endtask
    task automatic tk(int s, logic [4:0] wrapExp);
        tickSources <= 8'h01 << s;
        @(posedge clk);
        tickSources <= 8'h00;
        #1 chk("overflowSet", {11'h0, wrapExp}, {11'h0, overflowSet});
        @(posedge clk);
    endtask
    task automatic pins(logic [5:0] oe, logic [5:0] lvl);
        @(posedge clk);
        #1 chk("pinOe padLevel", {4'h0, oe, lvl}, {4'h0, pinOe, padLevel});
        @(posedge clk);
    endtask
    task automatic trig(logic [1:0] m, logic [7:0] ctl, logic [2:0] a, logic [7:0] d);
        combModeField <= m;
        wr(3'h1, 2'b01, {8'h00, ctl});
        ch1CaptureA <= 1'b1;
        wr(a, 2'b01, {8'h00, d});
    endtask
    function automatic logic [5:0] inv(int m, int o);
        if (m < 2) return 6'h00;
        return (o[1] ? 6'h00 : 6'h07) | (o[0] ? 6'h00 : 6'h38);
    endfunction
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(3'h0, 16'h00FF);
        rd(3'h1, 16'h00FF);
        for (int c = 0; c < 5; c++) rd(3'(c + 2), 16'h0000);
        wr(3'h0, 2'b01, 16'h0000);
        rd(3'h0, 16'h00C0);
        wr(3'h1, 2'b01, 16'h0000);
        rd(3'h1, 16'h00EC);
        wr(3'h7, 2'b11, 16'hFFFF);
        rd(3'h7, 16'h0000);
        $display("register test done");
        timerPinDrive <= 6'h3F;
        pins(6'h00, 6'h3F);
        for (int i = 0; i < 6; i++) begin
            wr(3'h0, 2'b01, 16'h0001 << i);
            pins(6'h01 << i, ~(6'h01 << i));
        end
        wr(3'h0, 2'b01, 16'h003F);
        timerPinLevel <= 6'h2A;
        for (int m = 0; m < 4; m++) begin
            combModeField <= 2'(m);
            for (int o = 0; o < 4; o++) begin
                wr(3'h1, 2'b01, 16'h0010 | 16'(o));
                pins(6'h3F, 6'h2A ^ inv(m, o));
            end
        end
        $display("pin test done");
        trig(2'b00, 8'h00, 3'h1, 8'h00);
        rd(3'h0, 16'h00FF);
        trig(2'b10, 8'h10, 3'h1, 8'h10);
        rd(3'h0, 16'h00FF);
        trig(2'b11, 8'h00, 3'h0, 8'hFF);
        rd(3'h0, 16'h00C0);
        pins(6'h00, 6'h3F);
        $display("trigger test done");
        wr(3'h2, 2'b11, 16'hFFFF);
        tk(7, 5'h01);
        rd(3'h2, 16'h0000);
        wr(3'h3, 2'b01, 16'h00AB);
        wr(3'h3, 2'b10, 16'hCD12);
        rd(3'h3, 16'hCDAB);
        countDownReq <= 5'h1F;
        for (int p = 0; p < 3; p++) begin
            combModeField <= (p == 0) ? 2'b10 : ((p == 1) ? 2'b00 : 2'b11);
            ch2PhaseMode <= (p == 0);
            for (int c = 0; c < 5; c++) begin
                dn = (p == 0) && (c > 1);
                wr(3'(c + 2), 2'b11, 16'h0000);
                tk(7 - c, dn ? 5'h01 << c : 5'h00);
                rd(3'(c + 2), dn ? 16'hFFFF : 16'h0001);
            end
        end
        clearReq <= 5'h10;
        @(posedge clk);
        clearReq <= 5'h00;
        rd(3'h6, 16'h0000);
        rd(3'h5, 16'h0001);
        $display("counter test done");
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        rd(3'h0, 16'h00FF);
        rd(3'h1, 16'h00FF);
        rd(3'h5, 16'h0000);
        $display("standby test done");
        print_verdict();
    end
endmodule
